/* bench/tb_data_transfer_instr_exec.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_data_transfer_instr_exec;
    import xfer_exec_pkg::*;
    logic        clock_i = 0, reset_i = 1, instr_valid_i = 0, debug_en_i = 0;
    logic        implicit_r0_i = 0, ready_o, done_o, dmem_rd_o, dmem_wr_o;
    logic        pmem_rd_o, io_wr_o, sleep_o, wdt_restart_o, break_o;
    op_t         instr_op_i = OP_NOP;
    ptr_t        ptr_sel_i = PTR_X;
    mode_t       ptr_mode_i = MODE_PLAIN;
    logic [4:0]  rd_i = 5'h00, rr_i = 5'h00, reg_peek_i = 5'h00;
    logic [5:0]  q_i = 6'h00, port_i = 6'h00, io_addr_o;
    logic [15:0] k_i = 16'h0000, pmem_rdata_i, dmem_addr_o, sp_o;
    logic [7:0]  imm_i = 8'h00, io_rdata_i, dmem_rdata_i, dmem_wdata_o;
    logic [7:0]  io_wdata_o, reg_peek_o;
    logic [14:0] pmem_addr_o;
    int          fail_count = 0, check_count = 0, cyc = 0;
    always #4 clock_i = ~clock_i;
    xfer_exec u_dut (.clock_i(clock_i), .reset_i(reset_i),
        .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
        .ptr_sel_i(ptr_sel_i), .ptr_mode_i(ptr_mode_i),
        .implicit_r0_i(implicit_r0_i), .rd_i(rd_i), .rr_i(rr_i), .q_i(q_i),
        .k_i(k_i), .imm_i(imm_i), .port_i(port_i), .io_rdata_i(io_rdata_i),
        .debug_en_i(debug_en_i), .dmem_rdata_i(dmem_rdata_i),
        .pmem_rdata_i(pmem_rdata_i), .reg_peek_i(reg_peek_i),
        .ready_o(ready_o), .done_o(done_o), .dmem_addr_o(dmem_addr_o),
        .dmem_rd_o(dmem_rd_o), .dmem_wr_o(dmem_wr_o),
        .dmem_wdata_o(dmem_wdata_o), .pmem_addr_o(pmem_addr_o),
        .pmem_rd_o(pmem_rd_o), .io_addr_o(io_addr_o), .io_wr_o(io_wr_o),
        .io_wdata_o(io_wdata_o), .sleep_o(sleep_o),
        .wdt_restart_o(wdt_restart_o), .break_o(break_o), .sp_o(sp_o),
        .reg_peek_o(reg_peek_o));
    xfer_mem_model u_mem (.clock_i, .addr_i(dmem_addr_o), .rd_i(dmem_rd_o),
        .wr_i(dmem_wr_o), .wdata_i(dmem_wdata_o), .rdata_o(dmem_rdata_i),
        .paddr_i(pmem_addr_o), .prd_i(pmem_rd_o), .prdata_o(pmem_rdata_i),
        .port_i, .io_o(io_rdata_i));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one idle edge first, so valid never falls and rises in one step
    task automatic run(input op_t op, input logic [15:0] n);
        logic [15:0] c;
        @(negedge clock_i);
        instr_op_i = op;
        instr_valid_i = 1;
        @(negedge clock_i);
        instr_valid_i = 0;
        c = 1;
        while (done_o !== 1'b1 && c < 8) begin
            @(negedge clock_i);
            c++;
        end
        chk(c, n);
    endtask
    task automatic peek(input logic [4:0] r, input logic [7:0] exp);
        reg_peek_i = r;
        @(negedge clock_i);
        chk({8'h00, reg_peek_o}, {8'h00, exp});
    endtask
    task automatic li(input logic [4:0] r, input logic [7:0] v);
        rd_i = r;
        imm_i = v;
        run(OP_LOAD_IMM, 1);
    endtask
    task automatic setp(input int p, input logic [15:0] v);
        ptr_sel_i = ptr_t'(p);
        li(5'd26 + 5'(2 * p), v[7:0]);
        li(5'd27 + 5'(2 * p), v[15:8]);
    endtask
    task automatic t_ptr;
        logic [15:0] a;
        for (int p = 0; p < 3; p++) begin
            for (int m = 0; m < 3; m++) begin
                ptr_mode_i = mode_t'(m);
                a = 16'h0400 + 16'(m == 1) - 16'(m == 2);
                setp(p, 16'h0400);
                rd_i = 5'd3;
                run(OP_READ_PTR, 2);
                peek(5'd3, (m == 2 ? 8'hff : 8'h00) ^ 8'h5a);
                peek(5'd26 + 5'(2 * p), a[7:0]);
                peek(5'd27 + 5'(2 * p), a[15:8]);
                li(5'd1, {p[3:0], m[3:0]});
                setp(p, 16'h0500);
                rr_i = 5'd1;
                run(OP_WRITE_PTR, 2);
                a = a + 16'h0100;
                peek(5'd26 + 5'(2 * p), a[7:0]);
                peek(5'd27 + 5'(2 * p), a[15:8]);
                k_i = 16'h0500 - 16'(m == 2);
                rd_i = 5'd2;
                run(OP_READ_DIR, 2);
                peek(5'd2, {p[3:0], m[3:0]});
            end
        end
        $display("pointer test done");
    endtask
    task automatic t_ofs;
        for (int p = 1; p < 3; p++) begin
            setp(p, {8'h05 + 8'(p), 8'h00});
            q_i = 6'h3f;
            rd_i = 5'd4;
            run(OP_READ_OFS, 2);
            peek(5'd4, 8'h3f ^ 8'h5a);
            li(5'd1, 8'h70 + 8'(p));
            rr_i = 5'd1;
            run(OP_WRITE_OFS, 2);
            peek(5'd26 + 5'(2 * p), 8'h00);
            k_i = {8'h05 + 8'(p), 8'h3f};
            rd_i = 5'd2;
            run(OP_READ_DIR, 2);
            peek(5'd2, 8'h70 + 8'(p));
        end
        $display("offset test done");
    endtask
    task automatic t_pmem;
        setp(2, 16'h0123);
        ptr_mode_i = MODE_POST_INC;
        rd_i = 5'd5;
        run(OP_READ_PMEM, 3);
        peek(5'd5, 8'h6e);
        ptr_mode_i = MODE_PLAIN;
        implicit_r0_i = 1;
        rd_i = 5'd9;
        run(OP_READ_PMEM, 3);
        implicit_r0_i = 0;
        peek(5'd0, 8'h92);
        peek(5'd9, 8'h00);
        peek(5'd30, 8'h24);
        $display("program read test done");
    endtask
    task automatic t_stack;
        li(5'd6, 8'hc3);
        rr_i = 5'd6;
        run(OP_PUSH, 2);
        chk(sp_o, 16'h10fe);
        k_i = 16'h10ff;
        rd_i = 5'd2;
        run(OP_READ_DIR, 2);
        peek(5'd2, 8'hc3);
        rd_i = 5'd7;
        run(OP_POP, 2);
        peek(5'd7, 8'hc3);
        chk(sp_o, 16'h10ff);
        li(5'd1, 8'h3c);
        k_i = 16'h0700;
        rr_i = 5'd1;
        run(OP_WRITE_DIR, 2);
        rd_i = 5'd2;
        run(OP_READ_DIR, 2);
        peek(5'd2, 8'h3c);
        $display("stack test done");
    endtask
    task automatic t_misc;
        li(5'd7, 8'h18);
        rd_i = 5'd10;
        rr_i = 5'd6;
        run(OP_COPY_PAIR, 1);
        peek(5'd10, 8'hc3);
        peek(5'd11, 8'h18);
        rd_i = 5'd12;
        rr_i = 5'd7;
        run(OP_COPY_REG, 1);
        peek(5'd12, 8'h18);
        port_i = 6'h15;
        rd_i = 5'd13;
        run(OP_PORT_IN, 1);
        peek(5'd13, 8'hb0);
        port_i = 6'h2a;
        rr_i = 5'd6;
        run(OP_PORT_OUT, 1);
        chk({2'h0, io_addr_o, io_wdata_o}, 16'h2ac3);
        chk({15'h0000, io_wr_o}, 16'h0001);
        run(OP_SLEEP, 1);
        chk({15'h0000, sleep_o}, 16'h0001);
        run(OP_WDOG, 1);
        chk({15'h0000, wdt_restart_o}, 16'h0001);
        run(OP_BREAK, 1);
        chk({15'h0000, break_o}, 16'h0000);
        debug_en_i = 1;
        run(OP_BREAK, 1);
        chk({15'h0000, break_o}, 16'h0001);
        $display("single cycle test done");
    endtask
    initial begin
        repeat (4) @(negedge clock_i);
        reset_i = 0;
        @(negedge clock_i);
        chk(sp_o, 16'h10ff);
        t_ptr;
        t_ofs;
        t_pmem;
        t_stack;
        t_misc;
        finish_test;
    end
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            finish_test;
        end
    end
endmodule
`default_nettype wire

/* bench/xfer_exec_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module xfer_exec_checker
    import xfer_exec_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        reset_i,
    input wire logic        instr_valid_i,
    input wire op_t         instr_op_i,
    input wire logic        debug_en_i,
    input wire logic        ready_o,
    input wire logic        done_o,
    input wire logic [15:0] dmem_addr_o,
    input wire logic        dmem_rd_o,
    input wire logic        dmem_wr_o,
    input wire logic        pmem_rd_o,
    input wire logic        sleep_o,
    input wire logic        wdt_restart_o,
    input wire logic        break_o,
    input wire logic [15:0] sp_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    wire logic acc = instr_valid_i & ready_o;
    wire logic dat = instr_op_i inside {OP_READ_PTR, OP_READ_OFS, OP_READ_DIR,
        OP_WRITE_PTR, OP_WRITE_OFS, OP_WRITE_DIR, OP_PUSH, OP_POP};
    wire logic one = instr_op_i inside {OP_COPY_REG, OP_COPY_PAIR, OP_LOAD_IMM,
        OP_PORT_IN, OP_PORT_OUT};
    property p_data;
        acc && dat |=> !ready_o && !done_o ##1 ready_o && done_o;
    endproperty
    a_data: assert property (p_data) else $error("data op timing");
    property p_pmem;
        acc && instr_op_i == OP_READ_PMEM |=> pmem_rd_o && !ready_o
            ##1 !pmem_rd_o && !done_o ##1 done_o && ready_o;
    endproperty
    a_pmem: assert property (p_pmem) else $error("pmem timing");
    property p_one;
        acc && one |=> done_o && ready_o && !dmem_rd_o && !dmem_wr_o;
    endproperty
    a_one: assert property (p_one) else $error("single op timing");
    property p_sleep;
        acc && instr_op_i == OP_SLEEP |=> sleep_o && done_o && ready_o;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep pulse");
    property p_wdog;
        acc && instr_op_i == OP_WDOG |=> wdt_restart_o && done_o;
    endproperty
    a_wdog: assert property (p_wdog) else $error("wdog pulse");
    property p_break;
        acc && instr_op_i == OP_BREAK |=> done_o
            && break_o == $past(debug_en_i);
    endproperty
    a_break: assert property (p_break) else $error("break pulse");
    property p_push;
        acc && instr_op_i == OP_PUSH |=> dmem_wr_o
            && dmem_addr_o == $past(sp_o) && sp_o == $past(sp_o) - 16'h0001;
    endproperty
    a_push: assert property (p_push) else $error("push access");
    property p_pop;
        acc && instr_op_i == OP_POP |=> dmem_rd_o && dmem_addr_o == sp_o
            && sp_o == $past(sp_o) + 16'h0001;
    endproperty
    a_pop: assert property (p_pop) else $error("pop access");
endmodule
bind xfer_exec xfer_exec_checker u_chk (.clock_i, .reset_i, .instr_valid_i,
    .instr_op_i, .debug_en_i, .ready_o, .done_o, .dmem_addr_o, .dmem_rd_o,
    .dmem_wr_o, .pmem_rd_o, .sleep_o, .wdt_restart_o, .break_o, .sp_o);
`default_nettype wire

/* bench/xfer_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module xfer_mem_model (
    input  wire logic        clock_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    input  wire logic [14:0] paddr_i,
    input  wire logic        prd_i,
    output logic      [15:0] prdata_o = 16'h0000,
    input  wire logic [5:0]  port_i,
    output logic      [7:0]  io_o
);
    logic [7:0] mem [65536];
    initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'h5a;
    // released bus shows the inverse so a stale byte cannot pass
    assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
    assign io_o = {2'h0, port_i} ^ 8'ha5;
    always @(posedge clock_i) begin
        if (wr_i)
            mem[addr_i] <= wdata_i;
        prdata_o <= prd_i ? {~paddr_i[7:0], paddr_i[7:0]} : ~prdata_o;
    end
endmodule
`default_nettype wire

/* hw/xfer_exec.sv */
`include "xfer_exec_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module xfer_exec (
    input  wire logic                 clock_i,
    input  wire logic                 reset_i,
    input  wire logic                 instr_valid_i,
    input  wire xfer_exec_pkg::op_t   instr_op_i,
    input  wire xfer_exec_pkg::ptr_t  ptr_sel_i,
    input  wire xfer_exec_pkg::mode_t ptr_mode_i,
    input  wire logic                 implicit_r0_i,
    input  wire logic [4:0]           rd_i,
    input  wire logic [4:0]           rr_i,
    input  wire logic [5:0]           q_i,
    input  wire logic [15:0]          k_i,
    input  wire logic [7:0]           imm_i,
    input  wire logic [5:0]           port_i,
    input  wire logic [7:0]           io_rdata_i,
    input  wire logic                 debug_en_i,
    input  wire logic [7:0]           dmem_rdata_i,
    input  wire logic [15:0]          pmem_rdata_i,
    input  wire logic [4:0]           reg_peek_i,
    output logic                      ready_o,
    output logic                      done_o,
    output logic [15:0]               dmem_addr_o,
    output logic                      dmem_rd_o,
    output logic                      dmem_wr_o,
    output logic [7:0]                dmem_wdata_o,
    output logic [14:0]               pmem_addr_o,
    output logic                      pmem_rd_o,
    output logic [5:0]                io_addr_o,
    output logic                      io_wr_o,
    output logic [7:0]                io_wdata_o,
    output logic                      sleep_o,
    output logic                      wdt_restart_o,
    output logic                      break_o,
    output logic [15:0]               sp_o,
    output logic [7:0]                reg_peek_o
);
    import xfer_exec_pkg::*;

    logic [7:0]  gpr_q [32];
    state_t      state_q;
    state_t      state_d;
    logic        ready_q;
    logic        done_q;
    logic [15:0] sp_q;
    logic [4:0]  dst_q;
    logic        rd_pend_q;
    logic        hi_sel_q;
    logic [15:0] dmem_addr_q;
    logic        dmem_rd_q;
    logic        dmem_wr_q;
    logic [7:0]  dmem_wdata_q;
    logic [14:0] pmem_addr_q;
    logic        pmem_rd_q;
    logic [5:0]  io_addr_q;
    logic        io_wr_q;
    logic [7:0]  io_wdata_q;
    logic        sleep_q;
    logic        wdt_q;
    logic        brk_q;
    logic [7:0]  peek_q;

    // decode of the accepted instruction
    wire acc      = ready_q & instr_valid_i;
    wire is_rptr  = instr_op_i == OP_READ_PTR;
    wire is_wptr  = instr_op_i == OP_WRITE_PTR;
    wire is_rofs  = instr_op_i == OP_READ_OFS;
    wire is_wofs  = instr_op_i == OP_WRITE_OFS;
    wire is_rdir  = instr_op_i == OP_READ_DIR;
    wire is_wdir  = instr_op_i == OP_WRITE_DIR;
    wire is_push  = instr_op_i == OP_PUSH;
    wire is_pop   = instr_op_i == OP_POP;
    wire is_pmem  = instr_op_i == OP_READ_PMEM;
    wire is_dread = is_rptr | is_rofs | is_rdir | is_pop;
    wire is_dwr   = is_wptr | is_wofs | is_wdir | is_push;
    wire is_dmem  = is_dread | is_dwr;

    // pointer pair selection and address arithmetic
    wire [4:0] ptr_lo = (ptr_sel_i == PTR_X) ? `PTR_X_LO :
                        (ptr_sel_i == PTR_Y) ? `PTR_Y_LO : `PTR_Z_LO;
    wire [4:0]  ptr_hi  = ptr_lo | `PAIR_HI_BIT;
    wire [15:0] ptr_val = {gpr_q[ptr_hi], gpr_q[ptr_lo]};
    wire [15:0] z_val   = {gpr_q[`PTR_Z_LO | `PAIR_HI_BIT], gpr_q[`PTR_Z_LO]};
    wire [15:0] ptr_inc = ptr_val + `ADDR_ONE;
    wire [15:0] ptr_dec = ptr_val - `ADDR_ONE;
    wire [15:0] ptr_ofs = ptr_val + {10'h000, q_i};
    wire        pre_dec = ptr_mode_i == MODE_PRE_DEC;
    wire        post    = ptr_mode_i == MODE_POST_INC;
    wire [15:0] sp_dec  = sp_q - `ADDR_ONE;
    wire [15:0] sp_inc  = sp_q + `ADDR_ONE;

    // effective data address; pre-decrement uses the lowered pointer
    wire [15:0] ptr_ea = pre_dec ? ptr_dec : ptr_val;
    wire [15:0] ea =
        (is_rptr | is_wptr) ? ptr_ea :
        (is_rofs | is_wofs) ? ptr_ofs :
        (is_rdir | is_wdir) ? k_i :
        is_push             ? sp_q :
        is_pop              ? sp_inc :
                              `ADDR_ZERO;

    // pointer write-back happens on the accepting edge, so the next
    // instruction already sees the moved pointer
    wire ptr_step = (is_rptr | is_wptr) & (post | pre_dec);
    // pre-decrement is not offered on program reads; it runs as plain
    wire z_step   = is_pmem & post;
    wire ptr_wr   = acc & (ptr_step | z_step);
    wire [15:0] ptr_new  = pre_dec ? ptr_dec : ptr_inc;
    wire [15:0] z_new    = z_val + `ADDR_ONE;
    wire [15:0] pair_ptr = is_pmem ? z_new : ptr_new;
    wire [4:0]  z_lo     = `PTR_Z_LO;
    wire [3:0]  pair_ptr_idx = is_pmem ? z_lo[4:1] : ptr_lo[4:1];

    // byte write sources: one-cycle ops, memory read, program read
    wire [7:0] rr_val = gpr_q[rr_i];
    wire [15:0] rr_pair = {gpr_q[{rr_i[4:1], 1'b1}], gpr_q[{rr_i[4:1], 1'b0}]};
    wire one_byte = acc & ((instr_op_i == OP_COPY_REG)
                  | (instr_op_i == OP_LOAD_IMM)
                  | (instr_op_i == OP_PORT_IN));
    wire [7:0] one_data =
        (instr_op_i == OP_COPY_REG) ? rr_val :
        (instr_op_i == OP_LOAD_IMM) ? imm_i : io_rdata_i;
    wire mem_byte  = (state_q == S_MEM) & rd_pend_q;
    wire pmem_byte = state_q == S_PCAP;
    wire [7:0] pm_data = hi_sel_q ? pmem_rdata_i[15:8] : pmem_rdata_i[7:0];
    wire       byte_en  = one_byte | mem_byte | pmem_byte;
    wire [4:0] byte_idx = one_byte ? rd_i : dst_q;
    wire [7:0] byte_dat = one_byte ? one_data :
                          mem_byte ? dmem_rdata_i : pm_data;

    wire copy_pair = acc & (instr_op_i == OP_COPY_PAIR);
    wire       pair_en  = copy_pair | ptr_wr;
    wire [3:0] pair_idx = copy_pair ? rd_i[4:1] : pair_ptr_idx;
    wire [15:0] pair_dat = copy_pair ? rr_pair : pair_ptr;

    // register file; pair and byte writes never share a cycle
    for (genvar i = 0; i < 32; i++) begin : g_gpr
        wire [4:0] idx = 5'(i);
        wire hit_b = byte_en & (byte_idx == idx);
        wire hit_p = pair_en & (pair_idx == idx[4:1]);
        wire [7:0] pv = idx[0] ? pair_dat[15:8] : pair_dat[7:0];
        always_ff @(posedge clock_i) begin
            if (reset_i) begin
                gpr_q[i] <= `BYTE_ZERO;
            end else if (hit_b) begin
                gpr_q[i] <= byte_dat;
            end else if (hit_p) begin
                gpr_q[i] <= pv;
            end
        end
    end

    // two-cycle ops visit S_MEM, program reads visit two extra states
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (acc & is_dmem) begin
                    state_d = S_MEM;
                end else if (acc & is_pmem) begin
                    state_d = S_PWAIT;
                end
            end
            S_MEM:   state_d = S_IDLE;
            S_PWAIT: state_d = S_PCAP;
            S_PCAP:  state_d = S_IDLE;
        endcase
    end

    // done stands one cycle, right after the edge the result landed on
    wire one_cycle = acc & ~is_dmem & ~is_pmem;
    wire done_d = one_cycle | (state_q == S_MEM) | (state_q == S_PCAP);
    wire sp_push = acc & is_push;
    wire sp_pop  = acc & is_pop;
    // break is inert unless the debug logic has claimed the core
    wire brk_d = acc & (instr_op_i == OP_BREAK) & debug_en_i;
    // destination is latched on accept so the inputs may move on
    wire [4:0] dst_d = (is_pmem & implicit_r0_i) ? `REG_R0 : rd_i;
    wire [7:0] wdata_d = (is_dwr & acc) ? rr_val : dmem_wdata_q;
    // ready drops on the accept edge of memory and program ops only; one-cycle ops leave it high, so a held valid is accepted again

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= S_IDLE;
            ready_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= state_d == S_IDLE;
            done_q  <= done_d;
        end
    end

    // stack grows down: push decrements after, pop increments before
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sp_q <= `SP_RESET;
        end else if (sp_push) begin
            sp_q <= sp_dec;
        end else if (sp_pop) begin
            sp_q <= sp_inc;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            dst_q     <= `REG_R0;
            rd_pend_q <= 1'b0;
            hi_sel_q  <= 1'b0;
        end else if (acc) begin
            dst_q     <= dst_d;
            rd_pend_q <= is_dread;
            hi_sel_q  <= z_val[0];
        end
    end

    // data memory strobes stand for the single second cycle
    // write data is held between writes, so memory never sees a stale bus
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            dmem_addr_q  <= `ADDR_ZERO;
            dmem_rd_q    <= 1'b0;
            dmem_wr_q    <= 1'b0;
            dmem_wdata_q <= `BYTE_ZERO;
        end else begin
            dmem_addr_q  <= (acc & is_dmem) ? ea : dmem_addr_q;
            dmem_rd_q    <= acc & is_dread;
            dmem_wr_q    <= acc & is_dwr;
            dmem_wdata_q <= wdata_d;
        end
    end

    // program memory is word wide; z bit 0 picks the byte
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            pmem_addr_q <= `WORD_ADDR_ZERO;
            pmem_rd_q   <= 1'b0;
        end else begin
            pmem_addr_q <= (acc & is_pmem) ? z_val[15:1] : pmem_addr_q;
            pmem_rd_q   <= acc & is_pmem;
        end
    end

    // port address and data follow every accepted instruction; only
    // io_wr_o qualifies them. peek trails the register file by one cycle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            io_addr_q  <= `PORT_ZERO;
            io_wr_q    <= 1'b0;
            io_wdata_q <= `BYTE_ZERO;
            sleep_q    <= 1'b0;
            wdt_q      <= 1'b0;
            brk_q      <= 1'b0;
            peek_q     <= `BYTE_ZERO;
        end else begin
            io_addr_q  <= acc ? port_i : io_addr_q;
            io_wr_q    <= acc & (instr_op_i == OP_PORT_OUT);
            io_wdata_q <= acc ? rr_val : io_wdata_q;
            sleep_q    <= acc & (instr_op_i == OP_SLEEP);
            wdt_q      <= acc & (instr_op_i == OP_WDOG);
            brk_q      <= brk_d;
            peek_q     <= gpr_q[reg_peek_i];
        end
    end

    assign ready_o       = ready_q;
    assign done_o        = done_q;
    assign dmem_addr_o   = dmem_addr_q;
    assign dmem_rd_o     = dmem_rd_q;
    assign dmem_wr_o     = dmem_wr_q;
    assign dmem_wdata_o  = dmem_wdata_q;
    assign pmem_addr_o   = pmem_addr_q;
    assign pmem_rd_o     = pmem_rd_q;
    assign io_addr_o     = io_addr_q;
    assign io_wr_o       = io_wr_q;
    assign io_wdata_o    = io_wdata_q;
    assign sleep_o       = sleep_q;
    assign wdt_restart_o = wdt_q;
    assign break_o       = brk_q;
    assign sp_o          = sp_q;
    assign reg_peek_o    = peek_q;
endmodule

`default_nettype wire

/* hw/xfer_exec_pkg.sv */
package xfer_exec_pkg;
    typedef enum logic [4:0] {
        OP_NOP, OP_COPY_REG, OP_COPY_PAIR, OP_LOAD_IMM,
        OP_PORT_IN, OP_PORT_OUT, OP_READ_PTR, OP_READ_OFS,
        OP_READ_DIR, OP_WRITE_PTR, OP_WRITE_OFS, OP_WRITE_DIR,
        OP_READ_PMEM, OP_PUSH, OP_POP, OP_SLEEP, OP_WDOG, OP_BREAK
    } op_t;
    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_t;
    typedef enum logic [1:0] {MODE_PLAIN, MODE_POST_INC, MODE_PRE_DEC} mode_t;
    typedef enum logic [1:0] {S_IDLE, S_MEM, S_PWAIT, S_PCAP} state_t;
endpackage

/* hw/xfer_exec_regs.svh */
`ifndef XFER_EXEC_REGS_SVH
`define XFER_EXEC_REGS_SVH
// register file indices of the three pointer pairs (low byte)
`define PTR_X_LO 5'd26
`define PTR_Y_LO 5'd28
`define PTR_Z_LO 5'd30
// implicit target of the operand-less program memory read
`define REG_R0 5'd0
// stack pointer after reset (plain default)
`define SP_RESET 16'h10ff
`define ADDR_ONE 16'h0001
`define BYTE_ZERO 8'h00
`define ADDR_ZERO 16'h0000
`define WORD_ADDR_ZERO 15'h0000
`define PORT_ZERO 6'h00
// odd register of a pointer pair holds the high byte
`define PAIR_HI_BIT 5'h01
`endif
